/* File: logic/pcint_pkg.sv */
// package: register map, field layout and shared types of the pin change block
package pcint_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int PCINT_PINS  = 8;   // pins per port
  localparam int PCINT_PORTS = 3;   // ports a, b, c
  localparam int PCINT_AW    = 6;   // byte address width

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [PCINT_AW-1:0] PCINT_OFF_PA_RISE = 6'h00;
  localparam logic [PCINT_AW-1:0] PCINT_OFF_PA_FALL = 6'h04;
  localparam logic [PCINT_AW-1:0] PCINT_OFF_PA_FLAG = 6'h08;
  localparam logic [PCINT_AW-1:0] PCINT_OFF_PB_RISE = 6'h0C;
  localparam logic [PCINT_AW-1:0] PCINT_OFF_PB_FALL = 6'h10;
  localparam logic [PCINT_AW-1:0] PCINT_OFF_PB_FLAG = 6'h14;
  localparam logic [PCINT_AW-1:0] PCINT_OFF_PC_RISE = 6'h18;
  localparam logic [PCINT_AW-1:0] PCINT_OFF_PC_FALL = 6'h1C;
  localparam logic [PCINT_AW-1:0] PCINT_OFF_PC_FLAG = 6'h20;
  localparam logic [PCINT_AW-1:0] PCINT_OFF_CTRL    = 6'h24;
  localparam logic [PCINT_AW-1:0] PCINT_OFF_STATUS  = 6'h28;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int PCINT_CTRL_MASTER_BIT  = 0;  // change_irq_master_enable
  localparam int PCINT_STAT_SUMMARY_BIT = 0;  // change_summary_flag
  localparam logic [7:0] PCINT_RST_ENABLE = 8'h00;
  localparam logic [7:0] PCINT_RST_FLAG   = 8'h00;
  localparam logic [31:0] PCINT_RD_ZERO   = 32'h0000_0000;

  // per-port configuration and state carried together
  typedef struct packed {
    logic [PCINT_PINS-1:0] rise;  // rise_enable_reg
    logic [PCINT_PINS-1:0] fall;  // fall_enable_reg
    logic [PCINT_PINS-1:0] flag;  // change_flag_reg
  } pcint_port_t;

  // classic wishbone request
  typedef struct packed {
    logic                cyc;
    logic                stb;
    logic                we;
    logic [3:0]          sel;
    logic [PCINT_AW-1:0] adr;
    logic [31:0]         dat;
  } pcint_wb_req_t;

endpackage : pcint_pkg

/* File: logic/pcint_top.sv */
// pin change detector for ports a, b, c with wishbone register slave
//
// Notes on behaviour
// - each pin has rise and fall detectors
// - rise enable bit qualifies rising edges
// - fall enable bit qualifies falling edges
// - both enables set detect either polarity
// - both enables clear never set flag
// - qualifying edge sets flag; master gates irq
// - master clear still detects and flags
// - summary flag is or of all flags
// - any pin combination may contribute
// - software clears flag by writing zero
// - edge during clear leaves flag set
// - enabled change event wakes from sleep
// - sleep edge recorded before wake executes
// - enable registers eight bits, reset zero
// - flag registers eight bits, hw set, reset zero
// - every pin on all ports supports detection
`timescale 1ns/1ps
`default_nettype none

module pcint_top
  import pcint_pkg::*;
#(
  parameter int PINS = PCINT_PINS  // pins per port
) (
  input  wire  logic                clk_i,       // system clock, 100 MHz
  input  wire  logic                rst_i,       // synchronous reset, high
  input  wire  logic                wb_cyc_i,    // wishbone cycle
  input  wire  logic                wb_stb_i,    // wishbone strobe
  input  wire  logic                wb_we_i,     // wishbone write
  input  wire  logic [3:0]          wb_sel_i,    // wishbone byte select
  input  wire  logic [PCINT_AW-1:0] wb_adr_i,    // wishbone byte address
  input  wire  logic [31:0]         wb_dat_i,    // wishbone write data
  output var   logic [31:0]         wb_dat_o,    // wishbone read data
  output var   logic                wb_ack_o,    // wishbone acknowledge
  input  wire  logic [PINS-1:0]     port_a_pin_i, // asynchronous port a pins
  input  wire  logic [PINS-1:0]     port_b_pin_i, // asynchronous port b pins
  input  wire  logic [PINS-1:0]     port_c_pin_i, // asynchronous port c pins
  output var   logic                change_irq_o, // interrupt request level
  output var   logic                wake_o        // sleep wake request level
);

  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  localparam int W = PINS * PCINT_PORTS;  // all pins flattened

  logic [W-1:0] pins_all;               // a in low bits, c in high bits
  logic [W-1:0] s1_r, s2_r, s3_r;       // three-stage sync chain
  logic [W-1:0] s1_nxt, s2_nxt, s3_nxt; // next values of the chain
  logic [W-1:0] lvl_r, lvl_nxt;         // accepted stable level

  assign pins_all = {port_c_pin_i, port_b_pin_i, port_a_pin_i};

  // chain: s1 is read by s2 only, filter looks at s2 and s3
  always_comb begin
    s1_nxt  = pins_all;
    s2_nxt  = s1_r;
    s3_nxt  = s2_r;
    lvl_nxt = lvl_r;
    for (int i = 0; i < W; i++) begin
      if (s2_r[i] == s3_r[i]) begin // change counts once both agree
        lvl_nxt[i] = s3_r[i];
      end
    end
  end

  // the chain registers; reset level zero so a high pin yields one rise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      lvl_r <= '0;
    end else begin
      s1_r  <= s1_nxt;
      s2_r  <= s2_nxt;
      s3_r  <= s3_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  // ---------------------------------------------------------------
  // edge detectors
  // ---------------------------------------------------------------
  logic [W-1:0] rise_ev;  // stable level went low to high
  logic [W-1:0] fall_ev;  // stable level went high to low

  // one event per accepted transition, so an edge sets a flag once
  assign rise_ev = lvl_nxt & ~lvl_r;
  assign fall_ev = ~lvl_nxt & lvl_r;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  pcint_port_t [PCINT_PORTS-1:0] port_r, port_nxt;  // per-port state
  logic                          master_r, master_nxt;  // irq master enable
  logic                          ack_r, ack_nxt;        // bus ack
  logic [31:0]                   rdat_r, rdat_nxt;      // bus read data
  logic                          irq_r, irq_nxt;        // irq output
  logic                          wake_r, wake_nxt;      // wake output
  logic                          summary;               // or of all flags
  logic                          req;                   // new bus access
  logic                          wr_b0;                 // write on lane 0
  logic [W-1:0]                  hit;                   // qualified edges
  logic [W-1:0]                  allflags;              // flattened flags

  // new access only while ack low: one ack per classic cycle
  assign req   = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr_b0 = req & wb_we_i & wb_sel_i[0];

  // qualification of each pin by its own enables
  always_comb begin
    for (int p = 0; p < PCINT_PORTS; p++) begin
      for (int b = 0; b < PINS; b++) begin
        hit[p*PINS+b] = (rise_ev[p*PINS+b] & port_r[p].rise[b])
                      | (fall_ev[p*PINS+b] & port_r[p].fall[b]);
        allflags[p*PINS+b] = port_r[p].flag[b];
      end
    end
  end

  assign summary = |allflags;

  // register write decode and flag update
  always_comb begin
    port_nxt   = port_r;
    master_nxt = master_r;
    // software writes first, hardware sets overlay them
    if (wr_b0) begin
      if (wb_adr_i == PCINT_OFF_PA_RISE) begin
        port_nxt[0].rise = wb_dat_i[7:0];
      end else if (wb_adr_i == PCINT_OFF_PA_FALL) begin
        port_nxt[0].fall = wb_dat_i[7:0];
      end else if (wb_adr_i == PCINT_OFF_PA_FLAG) begin
        port_nxt[0].flag = wb_dat_i[7:0];
      end else if (wb_adr_i == PCINT_OFF_PB_RISE) begin
        port_nxt[1].rise = wb_dat_i[7:0];
      end else if (wb_adr_i == PCINT_OFF_PB_FALL) begin
        port_nxt[1].fall = wb_dat_i[7:0];
      end else if (wb_adr_i == PCINT_OFF_PB_FLAG) begin
        port_nxt[1].flag = wb_dat_i[7:0];
      end else if (wb_adr_i == PCINT_OFF_PC_RISE) begin
        port_nxt[2].rise = wb_dat_i[7:0];
      end else if (wb_adr_i == PCINT_OFF_PC_FALL) begin
        port_nxt[2].fall = wb_dat_i[7:0];
      end else if (wb_adr_i == PCINT_OFF_PC_FLAG) begin
        port_nxt[2].flag = wb_dat_i[7:0];
      end else if (wb_adr_i == PCINT_OFF_CTRL) begin
        master_nxt = wb_dat_i[PCINT_CTRL_MASTER_BIT];
      end
    end
    // a concurrent edge wins over the clear, whatever was written
    for (int p = 0; p < PCINT_PORTS; p++) begin
      port_nxt[p].flag = port_nxt[p].flag | hit[p*PINS +: PINS];
    end
  end

  // read mux, ack and outputs
  always_comb begin
    ack_nxt  = req;  // single-cycle answer, dropped the cycle after
    rdat_nxt = PCINT_RD_ZERO;
    if (req & ~wb_we_i) begin
      if (wb_adr_i == PCINT_OFF_PA_RISE) begin
        rdat_nxt[7:0] = port_r[0].rise;
      end else if (wb_adr_i == PCINT_OFF_PA_FALL) begin
        rdat_nxt[7:0] = port_r[0].fall;
      end else if (wb_adr_i == PCINT_OFF_PA_FLAG) begin
        rdat_nxt[7:0] = port_r[0].flag;
      end else if (wb_adr_i == PCINT_OFF_PB_RISE) begin
        rdat_nxt[7:0] = port_r[1].rise;
      end else if (wb_adr_i == PCINT_OFF_PB_FALL) begin
        rdat_nxt[7:0] = port_r[1].fall;
      end else if (wb_adr_i == PCINT_OFF_PB_FLAG) begin
        rdat_nxt[7:0] = port_r[1].flag;
      end else if (wb_adr_i == PCINT_OFF_PC_RISE) begin
        rdat_nxt[7:0] = port_r[2].rise;
      end else if (wb_adr_i == PCINT_OFF_PC_FALL) begin
        rdat_nxt[7:0] = port_r[2].fall;
      end else if (wb_adr_i == PCINT_OFF_PC_FLAG) begin
        rdat_nxt[7:0] = port_r[2].flag;
      end else if (wb_adr_i == PCINT_OFF_CTRL) begin
        rdat_nxt[PCINT_CTRL_MASTER_BIT] = master_r;
      end else if (wb_adr_i == PCINT_OFF_STATUS) begin
        rdat_nxt[PCINT_STAT_SUMMARY_BIT] = summary;
      end
      // unmapped addresses read zero and still ack
    end
    // flags keep setting with master off, only the irq and wake requests are held back
    irq_nxt  = master_r & summary;
    // wake uses the same gated event; flags are already latched so the
    // core sees them before its first instruction after wake
    wake_nxt = master_r & summary;
  end

  // state registers; every reset returns all registers to zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int p = 0; p < PCINT_PORTS; p++) begin
        port_r[p].rise <= PCINT_RST_ENABLE;
        port_r[p].fall <= PCINT_RST_ENABLE;
        port_r[p].flag <= PCINT_RST_FLAG;
      end
      master_r <= 1'b0;
      ack_r    <= 1'b0;
      rdat_r   <= PCINT_RD_ZERO;
      irq_r    <= 1'b0;
      wake_r   <= 1'b0;
    end else begin
      port_r   <= port_nxt;
      master_r <= master_nxt;
      ack_r    <= ack_nxt;
      rdat_r   <= rdat_nxt;
      irq_r    <= irq_nxt;
      wake_r   <= wake_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign wb_ack_o     = ack_r;
  assign wb_dat_o     = rdat_r;
  assign change_irq_o = irq_r;
  assign wake_o       = wake_r;

endmodule : pcint_top

`default_nettype wire

/* File: test/pcint_pins.sv */
// pin driver model for ports a, b and c
`timescale 1ns/1ps
`default_nettype none
module pcint_pins (
  input  wire logic        clk_i,   // clock
  input  wire logic        slow_i,  // lag one more cycle
  input  wire logic [23:0] lvl_i,   // wanted levels c, b, a
  output var  logic [23:0] pin_o    // pin levels c, b, a
);
  logic [23:0] dly_r;  // staged levels for slow mode
  // pins move just after an edge, as a synchronous source would
  always_ff @(posedge clk_i) begin
    dly_r <= lvl_i;
    pin_o <= slow_i ? dly_r : lvl_i;
  end
endmodule : pcint_pins
`default_nettype wire

/* File: test/pcint_chk.sv */
// port checks of the pin change block
`timescale 1ns/1ps
`default_nettype none
module pcint_chk (
  input wire logic        clk_i,         // clock
  input wire logic        rst_i,         // reset
  input wire logic        wb_cyc_i,      // cycle
  input wire logic        wb_stb_i,      // strobe
  input wire logic        wb_we_i,       // write
  input wire logic [31:0] wb_dat_o,      // read data
  input wire logic        wb_ack_o,      // ack
  input wire logic        change_irq_o,  // irq
  input wire logic        wake_o         // wake
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a request the slave has not answered yet
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // one ack cycle, then quiet
  sequence s_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_latency_a: assert property (s_take |=> s_answer)
    else $error("ack not one cycle after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  wake_irq_a: assert property (wake_o == change_irq_o)
    else $error("wake differs from irq");
  irq_sticky_a: assert property ($fell(change_irq_o) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i, 2))
    else $error("irq dropped without write");
  reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !change_irq_o)
    else $error("outputs active after reset");
endmodule : pcint_chk
bind pcint_top pcint_chk i_pcint_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .change_irq_o(change_irq_o), .wake_o(wake_o));
`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench for the pin change block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pcint_pkg::*;
  logic          clk_i;                 // clock
  logic          rst_i = 1'b1;          // reset
  logic          slow = 1'b0;           // lazy pins
  pcint_wb_req_t req = '0;              // bus request
  logic [31:0]   dout, rdat;            // read data, last read
  logic          ack, irq, wake;        // answers
  logic [23:0]   lvl = '0, pins;        // wanted, driven pins
  int            fail_count = 0, samples_checked = 0, cycles = 0;  // tallies
  pcint_top i_pcint_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
    .wb_we_i(req.we), .wb_sel_i(req.sel), .wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_dat_o(dout),
    .wb_ack_o(ack), .port_a_pin_i(pins[7:0]), .port_b_pin_i(pins[15:8]), .port_c_pin_i(pins[23:16]),
    .change_irq_o(irq), .wake_o(wake));
  pcint_pins i_pcint_pins (.clk_i(clk_i), .slow_i(slow), .lvl_i(lvl), .pin_o(pins));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // the run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (fail_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // one classic cycle; a read is compared with d
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, w, 4'hF, a, d};
    do @(posedge clk_i); while (ack !== 1'b1 && ++n < 50);
    if (n >= 50) fail_count++;
    rdat = dout;
    req <= '0;
    @(posedge clk_i);
    if (!w) check(rdat, d);
  endtask : bus
  // masked clear writes back the value it read, with the known bits cleared
  task automatic clear(input logic [5:0] a, input logic [31:0] known);
    bus(1'b0, a, known);
    bus(1'b1, a, rdat & ~known);
  endtask : clear
  task automatic drive(input logic [23:0] v);
    @(posedge clk_i);
    lvl <= v;
    repeat (10) @(posedge clk_i);
  endtask : drive
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 12; i++) bus(1'b0, 6'(4 * i), 32'h0);
    for (int i = 0; i < 36; i += 12) begin
      bus(1'b1, 6'(i), 32'hFFFF_FF0F);
      bus(1'b1, 6'(i + 4), 32'hFFFF_FFF0);
      bus(1'b0, 6'(i + 4), 32'hF0);
    end
    drive(24'hFF_FFFF);
    for (int i = 8; i < 36; i += 12) bus(1'b0, 6'(i), 32'h0F);
    check(32'({irq, wake}), 32'h0);
    bus(1'b0, PCINT_OFF_STATUS, 32'h1);
    drive(24'h0);
    bus(1'b1, PCINT_OFF_CTRL, 32'h1);
    repeat (2) @(posedge clk_i);
    check(32'({irq, wake}), 32'h3);
    for (int i = 8; i < 36; i += 12) clear(6'(i), 32'hFF);
    bus(1'b0, PCINT_OFF_STATUS, 32'h0);
    check(32'({irq, wake}), 32'h0);
    slow <= 1'b1;
    for (int i = 0; i < 5; i++) if (i != 2) bus(1'b1, 6'(4 * i), i < 2 ? 32'h0 : 32'h81);
    drive(24'hFF_FFFF);
    bus(1'b0, PCINT_OFF_PA_FLAG, 32'h0);
    clear(PCINT_OFF_PB_FLAG, 32'h81);
    drive(24'h0);
    bus(1'b0, PCINT_OFF_PB_FLAG, 32'h81);
    // port c rises land in the very cycle the clear is taken: set must win
    @(posedge clk_i);
    lvl <= 24'hFF_FFFF;
    repeat (4) @(posedge clk_i);
    bus(1'b1, PCINT_OFF_PC_FLAG, 32'h0);
    bus(1'b0, PCINT_OFF_PC_FLAG, 32'h0F);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
